// *** rsc_pkg.sv ***
// constants and carrier types for the reset source controller
package rsc_pkg;
  localparam logic [7:0] RSC_SUPPLY_MONITOR_CONTROL_ADDR = 8'hff;
  localparam logic [7:0] RSC_RESET_CAUSE_REGISTER_ADDR   = 8'hef;
  localparam int         RSC_MON_ON_BIT      = 7;
  localparam int         RSC_MON_STATUS_BIT  = 6;
  localparam int         RSC_PIN_BIT         = 0;
  localparam int         RSC_POR_BIT         = 1;
  localparam int         RSC_CLK_LOSS_BIT    = 2;
  localparam int         RSC_WDOG_BIT        = 3;
  localparam int         RSC_SW_BIT          = 4;
  localparam int         RSC_CMP_BIT         = 5;
  localparam int         RSC_FLASH_BIT       = 6;
  localparam logic       RSC_MON_ON_RESET    = 1'b1;
  localparam logic [7:0] RSC_CAUSE_RESET     = 8'h02;
  localparam logic [15:0] RSC_USER_CODE_TOP  = 16'h3dff;
  localparam int         RSC_CLK_MHZ         = 100;
  localparam int         RSC_CLK_LOSS_US     = 100;
  localparam int         RSC_CLK_LOSS_CYCLES = RSC_CLK_LOSS_US * RSC_CLK_MHZ;
  localparam int         RSC_WDOG_DIV        = 12;
  localparam int         RSC_HOLD_CYCLES     = 4;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } rsc_sfr_req_t;

  typedef struct packed {
    logic        xdata_wr;
    logic        code_rd;
    logic        fetch;
    logic        security_violation;
    logic [15:0] addr;
  } rsc_flash_acc_t;

  typedef struct packed {
    logic flash;
    logic cmp;
    logic sw;
    logic wdog;
    logic clk_loss;
    logic por;
    logic pin;
  } rsc_cause_t;
endpackage : rsc_pkg

// *** rsc_reset_source_controller.sv ***
// reset source controller: gathers reset requests and records the last cause
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1: supply low drives pin low, holds CPU
// R2: only power-on enables supply monitor
// R3: no power-on delay after monitor reset
// R4: software enables monitor before selecting it
// R5: early monitor selection may cause reset
// R6: bit 7 switches monitor; gated by selection
// R7: bit 6 shows live monitor output
// R8: monitor control bits 5:0 read zero
// R9: low reset pin resets, sets pin flag
// R10: enabled clock-loss detector resets on timeout
// R11: bit 2 flags clock loss, enables detector
// R12: internal sources never drive reset pin
// R13: bit 5 arms comparator reset and flags
// R14: software settles comparator before arming
// R15: watchdog enabled at system_clock/12 after reset
// R16: watchdog timeout resets, sets bit 3
// R17: flash write above user space resets
// R18: code read or fetch above top resets
// R19: security-forbidden flash access resets
// R20: flash error sets bit 6
// R21: writing bit 4 forces software reset
// R22: power-on flag; writing selects monitor
// R23: power-on flag set; others clear it
// R24: flags captured at reset, held after
module rsc_reset_source_controller
  import rsc_pkg::*;
#(
  parameter int POR_DELAY_CYCLES  = 30000,
  parameter int CLK_LOSS_CYCLES   = RSC_CLK_LOSS_CYCLES
)(
  input  wire logic           sys_clk,
  input  wire logic           resetn,
  input  wire logic           power_on_n,
  input  wire logic           supply_above,
  input  wire logic           reset_pin_in,
  output logic                reset_pin_out,
  output logic                reset_pin_oe,
  input  wire logic           system_clock_stalled,
  input  wire logic           comparator_out,
  input  wire logic           watchdog_timeout,
  input  wire logic           flash_write_enable,
  input  wire rsc_flash_acc_t flash_acc,
  input  wire rsc_sfr_req_t   sfr_req,
  output logic [7:0]          sfr_rdata,
  output logic                system_reset,
  output logic                watchdog_enable,
  output logic                watchdog_tick
);

  typedef enum logic [1:0] {RSC_RUN, RSC_HOLD, RSC_POR_WAIT} rsc_state_t;

  rsc_state_t  state;
  rsc_cause_t  pending;
  rsc_cause_t  cause;
  logic        supply_monitor_on;
  logic        monitor_selected;
  logic        clock_loss_enable;
  logic        comparator_armed;
  logic        from_power_on;
  logic [31:0] timer;
  logic [31:0] stall_cnt;
  logic [3:0]  wdog_div;

  // register decode
  wire wr_mon   = sfr_req.wr && sfr_req.addr == RSC_SUPPLY_MONITOR_CONTROL_ADDR;
  wire wr_cause = sfr_req.wr && sfr_req.addr == RSC_RESET_CAUSE_REGISTER_ADDR;
  wire running  = state == RSC_RUN;

  // request conditions
  wire mon_req   = supply_monitor_on && monitor_selected && !supply_above; // R6
  wire spur_req  = wr_cause && sfr_req.wdata[RSC_POR_BIT] && !supply_monitor_on; // R5
  // our own pull on the pin must not read back as an outside request, or the hold never ends
  wire pin_req   = !reset_pin_in && !reset_pin_oe; // R9
  wire loss_req  = clock_loss_enable && stall_cnt >= 32'(CLK_LOSS_CYCLES); // R10
  wire cmp_req   = comparator_armed && !comparator_out; // R13
  wire sw_req    = wr_cause && sfr_req.wdata[RSC_SW_BIT]; // R21
  wire wdog_req  = watchdog_enable && watchdog_timeout; // R16
  wire above_top = flash_acc.addr > RSC_USER_CODE_TOP;
  wire fl_req    = (flash_acc.xdata_wr && flash_write_enable && above_top) // R17
                 || ((flash_acc.code_rd || flash_acc.fetch) && above_top) // R18
                 || flash_acc.security_violation; // R19
  wire por_req   = !power_on_n || mon_req || spur_req;

  // priority: power-on class first, then pin, then internal sources
  wire any_req   = por_req || pin_req || loss_req || cmp_req || sw_req || wdog_req || fl_req;
  rsc_cause_t next_cause;
  assign next_cause.por      = por_req; // R23
  assign next_cause.pin      = !por_req && pin_req;
  assign next_cause.clk_loss = !por_req && !pin_req && loss_req;
  assign next_cause.cmp      = !por_req && !pin_req && !loss_req && cmp_req;
  assign next_cause.wdog     = !por_req && !pin_req && !loss_req && !cmp_req && wdog_req;
  assign next_cause.flash    = !por_req && !pin_req && !loss_req && !cmp_req && !wdog_req && fl_req;
  assign next_cause.sw       = !por_req && !pin_req && !loss_req && !cmp_req && !wdog_req && !fl_req
                               && sw_req;

  // while a request persists, the newest request sets the cause unless power-on is already pending
  rsc_cause_t merged;
  assign merged = pending.por ? pending : (any_req ? next_cause : pending);

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state   <= RSC_POR_WAIT;
      pending <= RSC_CAUSE_RESET[6:0];
      cause   <= RSC_CAUSE_RESET[6:0];
      timer   <= '0;
    end
    else
    begin
      case (state)
        RSC_RUN:
          if (any_req)
          begin
            state   <= RSC_HOLD;
            pending <= next_cause; // R24
            timer   <= '0;
          end
        RSC_HOLD:
          if (any_req)
          begin
            pending <= merged;
            timer   <= '0;
          end
          else if (timer < 32'(RSC_HOLD_CYCLES))
            timer <= timer + 32'd1;
          else if (from_power_on)
          begin
            state <= RSC_POR_WAIT;
            timer <= '0; // R3
          end
          else
          begin
            state <= RSC_RUN;
            cause <= pending; // R24
          end
        RSC_POR_WAIT:
          if (any_req)
          begin
            state   <= RSC_HOLD;
            pending <= merged;
            timer   <= '0;
          end
          else if (timer < 32'(POR_DELAY_CYCLES))
            timer <= timer + 32'd1;
          else
          begin
            state <= RSC_RUN;
            cause <= RSC_CAUSE_RESET[6:0]; // R23
          end
        default:
          state <= RSC_POR_WAIT;
      endcase
    end
  end

  // only the power-on detector itself pays the release delay; a monitor reset does not
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      from_power_on <= 1'b1;
    else if (running && any_req)
      from_power_on <= !power_on_n; // R3
    else if (!running && any_req)
      from_power_on <= from_power_on || !power_on_n; // R3
  end

  // supply monitor enable survives all resets except power-on
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !power_on_n)
      supply_monitor_on <= RSC_MON_ON_RESET; // R2
    else if (wr_mon && running)
      supply_monitor_on <= sfr_req.wdata[RSC_MON_ON_BIT]; // R6
  end

  // source selections cleared by every reset
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !running)
    begin
      monitor_selected  <= 1'b0;
      clock_loss_enable <= 1'b0;
      comparator_armed  <= 1'b0;
    end
    else if (wr_cause)
    begin
      if (sfr_req.wdata[RSC_POR_BIT])
        monitor_selected <= 1'b1; // R22
      clock_loss_enable <= sfr_req.wdata[RSC_CLK_LOSS_BIT]; // R11
      if (sfr_req.wdata[RSC_CMP_BIT])
        comparator_armed <= 1'b1; // R13
    end
  end

  // stall counter counts while the clock monitor sees no edges
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !system_clock_stalled)
      stall_cnt <= '0;
    else if (stall_cnt < 32'(CLK_LOSS_CYCLES))
      stall_cnt <= stall_cnt + 32'd1; // R10
  end

  // watchdog clock enable, system_clock divided by twelve
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !running)
      wdog_div <= '0;
    else if (wdog_div == 4'(RSC_WDOG_DIV - 1))
      wdog_div <= '0; // R15
    else
      wdog_div <= wdog_div + 4'd1;
  end

  assign watchdog_tick   = running && wdog_div == 4'(RSC_WDOG_DIV - 1); // R15
  assign watchdog_enable = 1'b1; // R15

  assign system_reset  = !running;
  // pin driven low only for the power-on class; other sources leave it alone
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = por_req || (state != RSC_RUN && pending.por); // R1 R12

  // read mux; flags other than power-on read zero while it is set
  wire [7:0] mon_rd   = {supply_monitor_on, supply_above, 6'h00}; // R7 R8
  wire [7:0] cause_rd = cause.por ? 8'h02 :
                        {1'b0, cause.flash, cause.cmp, cause.sw, cause.wdog,
                         cause.clk_loss, 1'b0, cause.pin}; // R9 R11 R16 R20 R21
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd && sfr_req.addr == RSC_SUPPLY_MONITOR_CONTROL_ADDR)
      sfr_rdata <= mon_rd;
    else if (sfr_req.rd && sfr_req.addr == RSC_RESET_CAUSE_REGISTER_ADDR)
      sfr_rdata <= cause_rd;
    else
      sfr_rdata <= 8'h00;
  end

endmodule : rsc_reset_source_controller
`default_nettype wire

// *** rsc_reset_source_controller_assertions.sv ***
// port checker for the reset source controller
`timescale 1ns/1ns
`default_nettype none
module rsc_checker
  import rsc_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           resetn,
  input wire logic           power_on_n,
  input wire logic           reset_pin_in,
  input wire logic           reset_pin_out,
  input wire logic           reset_pin_oe,
  input wire logic           watchdog_timeout,
  input wire logic           watchdog_enable,
  input wire logic           watchdog_tick,
  input wire rsc_flash_acc_t flash_acc,
  input wire rsc_sfr_req_t   sfr_req,
  input wire logic           system_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence sw_req;
    sfr_req.wr && sfr_req.addr == 8'hef && sfr_req.wdata == 8'h10 && !system_reset;
  endsequence
  sequence held_five;
    system_reset [*5];
  endsequence
  chk_pin_open_drain: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  chk_por_pin_low: assert property (!power_on_n |=> system_reset && reset_pin_oe)
    else $error("power-on did not pull pin");
  chk_pin_request: assert property (!reset_pin_in && !reset_pin_oe && !system_reset |=> system_reset)
    else $error("pin low ignored");
  chk_sw_force: assert property (sw_req |=> system_reset && !reset_pin_oe)
    else $error("software reset wrong");
  chk_wdog_reset: assert property (watchdog_timeout && !system_reset |=> system_reset && !reset_pin_oe)
    else $error("watchdog reset wrong");
  chk_fetch_above: assert property (flash_acc.fetch && flash_acc.addr > RSC_USER_CODE_TOP && !system_reset
    |=> system_reset)
    else $error("fetch above top ignored");
  chk_reset_hold: assert property ($rose(system_reset) |-> held_five)
    else $error("reset too short");
  chk_wdog_running: assert property ($fell(system_reset) |-> ##[1:11] (watchdog_tick || system_reset))
    else $error("watchdog off after reset");
  chk_wdog_period: assert property (watchdog_tick |=> !watchdog_tick [*8])
    else $error("watchdog tick too fast");
endmodule : rsc_checker
`default_nettype wire

// *** rsc_pin_partner.sv ***
// external circuitry on the open-drain reset pin
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_partner
(
  input  wire logic hold_low,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  // pull-up wins unless a party sinks the line
  assign pin_level = !(hold_low || (pin_oe && !pin_out));
endmodule : rsc_pin_partner
`default_nettype wire

// *** tb_reset_source_controller.sv ***
// self-checking bench for the reset source controller
`timescale 1ns/1ns
`default_nettype none
module tb_reset_source_controller
  import rsc_pkg::*;
;
  logic           sys_clk, resetn, pwr_n, sup, hold, pin_lvl, pin_out, pin_oe, stall, cmp, wdt, fwe;
  logic           sys_rst, wd_en, wd_tick;
  rsc_flash_acc_t fa;
  rsc_sfr_req_t   req;
  logic [7:0]     rdata;
  int             n_mismatch, n_checks, n;
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  rsc_pin_partner i_pin (.hold_low(hold), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_lvl));
  rsc_reset_source_controller #(.POR_DELAY_CYCLES(40), .CLK_LOSS_CYCLES(16)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .power_on_n(pwr_n), .supply_above(sup),
    .reset_pin_in(pin_lvl), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .system_clock_stalled(stall), .comparator_out(cmp), .watchdog_timeout(wdt),
    .flash_write_enable(fwe), .flash_acc(fa), .sfr_req(req), .sfr_rdata(rdata),
    .system_reset(sys_rst), .watchdog_enable(wd_en), .watchdog_tick(wd_tick));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    req = '0;
    chk(rdata, exp);
  endtask : rd
  task automatic wait_rel();
    n = 0;
    while (sys_rst !== 1'b0 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 300)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_rel
  // drops the pin, stall, watchdog, flash and comparator requests, then checks the recorded cause
  task automatic cause(input logic [7:0] exp);
    @(negedge sys_clk);
    {hold, stall, wdt, fa} = '0;
    cmp = 1'b1;
    @(negedge sys_clk);
    chk({7'h0, sys_rst}, 8'h01);
    wait_rel();
    rd(8'hef, exp);
  endtask : cause
  task automatic t_power_on();
    int t = 0;
    wait_rel();
    chk({7'h0, n > 30}, 8'h01);
    rd(8'hff, 8'hc0);
    rd(8'hef, 8'h02);
    chk({7'h0, wd_en}, 8'h01);
    repeat (24)
    begin
      @(negedge sys_clk);
      t += int'(wd_tick);
    end
    chk(8'(t), 8'h02);
  endtask : t_power_on
  task automatic t_monitor();
    wr(8'hef, 8'h02);
    sup = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({6'h0, sys_rst, pin_lvl}, 8'h02);
    sup = 1'b1;
    wait_rel();
    chk({7'h0, n < 20}, 8'h01);
    rd(8'hef, 8'h02);
  endtask : t_monitor
  task automatic t_sources();
    wr(8'hef, 8'h20);
    cmp = 1'b0;
    cause(8'h20);
    wdt = 1'b1;
    cause(8'h08);
    wr(8'hef, 8'h04);
    stall = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk({7'h0, pin_oe}, 8'h00);
    cause(8'h04);
    hold = 1'b1;
    repeat (3) @(negedge sys_clk);
    cause(8'h01);
  endtask : t_sources
  task automatic t_flash();
    fa = '{xdata_wr: 1'b0, code_rd: 1'b0, fetch: 1'b1, security_violation: 1'b0, addr: 16'h3dff};
    @(negedge sys_clk);
    fa = '0;
    repeat (2) @(negedge sys_clk);
    chk({7'h0, sys_rst}, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      fa = {4'h1 << k, 16'h3e00};
      cause(8'h40);
    end
  endtask : t_flash
  task automatic t_software();
    wr(8'hff, 8'h3f);
    rd(8'hff, 8'h40);
    wr(8'hef, 8'h10);
    cause(8'h10);
    rd(8'hff, 8'h40);
    wr(8'hef, 8'h02);
    cause(8'h02);
    rd(8'hff, 8'h40);
    pwr_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    pwr_n = 1'b1;
    wait_rel();
    chk({7'h0, n > 30}, 8'h01);
    rd(8'hff, 8'hc0);
    rd(8'hef, 8'h02);
  endtask : t_software
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial
  begin
    {resetn, hold, stall, wdt, fa, req} = '0;
    {pwr_n, sup, cmp, fwe} = '1;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    t_power_on();
    t_monitor();
    t_sources();
    t_flash();
    t_software();
    wrap_up();
  end
endmodule : tb_reset_source_controller
bind rsc_reset_source_controller rsc_checker i_chk (.sys_clk, .resetn, .power_on_n, .reset_pin_in,
  .reset_pin_out, .reset_pin_oe, .watchdog_timeout, .watchdog_enable, .watchdog_tick, .flash_acc, .sfr_req,
  .system_reset);
`default_nettype wire
